// ==== rtl/chroma_path_pkg.sv ====
// Shared constants and types of the chroma transient output path.
// Assumes one system clock; every stage advances only while the clock enable ce is high.
package chroma_path_pkg;
  localparam int              ADDR_W        = 4;
  localparam logic [3:0]      ADDR_CTRL     = 4'h0;
  localparam logic [3:0]      ADDR_SAT      = 4'h1;
  localparam logic [3:0]      ADDR_SHARP    = 4'h2;
  localparam logic [3:0]      ADDR_WIN      = 4'h3;
  localparam logic [3:0]      ADDR_STATUS   = 4'h4;
  localparam int              CTRL_EN_BIT   = 0;
  localparam int              CTRL_FSEL_BIT = 1;
  localparam int              CTRL_FMT_LSB  = 2;
  localparam int              CTRL_STD_BIT  = 4;
  localparam int              CTRL_LEAD_LSB = 5;
  localparam logic [6:0]      CTRL_RST      = 7'h00;
  localparam logic [15:0]     SAT_RST       = 16'h4040;
  localparam logic [20:0]     SHARP_RST     = 21'h000000;
  localparam logic [31:0]     WIN_RST       = 32'h00000000;
  localparam int              GAINU_LSB     = 0;
  localparam int              GAINV_LSB     = 5;
  localparam int              THR_LSB       = 10;
  localparam int              COR_LSB       = 17;
  localparam int              SAT_SHIFT     = 7;
  localparam int              GAIN_SHIFT    = 3;
  localparam logic signed [17:0] CLAMP_HI   = 18'sh0007F;
  localparam logic signed [17:0] CLAMP_LO   = -18'sh00080;
  localparam logic signed [9:0]  BLACK_NATIVE = 10'sh020;
  localparam logic signed [17:0] BLACK_STUDIO = 18'sh00010;
  localparam logic signed [17:0] WHITE_STUDIO = 18'sh000F0;
  localparam logic signed [8:0]  STUDIO_MUL   = 9'sh097;
  localparam int              STUDIO_SHIFT  = 6;
  localparam int              V_STEP_SHIFT  = 1;
  localparam int              H_STEP_SHIFT  = 3;
  localparam int              LUMA_LAG      = 8;
  localparam int              LAG_AW        = 3;
  typedef enum logic [1:0] {
    FMT_NONORTH = 2'h0,
    FMT_ORTH422 = 2'h1,
    FMT_ORTH411 = 2'h2
  } format_type;
  typedef enum logic [3:0] {
    PH0 = 4'h1,
    PH1 = 4'h2,
    PH2 = 4'h4,
    PH3 = 4'h8
  } phase_type;
endpackage

// ==== rtl/luma_delay_if.sv ====
// Port bundle between the path and its luma delay memory.
// Assumes the path drives address and write data, the memory answers.
`timescale 1ns/1ps
interface luma_delay_if;
  logic       wrEn;
  logic [2:0] addr;
  logic [7:0] wrData;
  logic [7:0] rdData;
  modport owner (output wrEn, output addr, output wrData, input rdData);
  modport store (input wrEn, input addr, input wrData, output rdData);
endinterface

// ==== rtl/luma_delay_mem.sv ====
// Small luma delay memory with registered read data.
// Assumes read and write at one address per cycle; read sees the old word.
`timescale 1ns/1ps
module luma_delay_mem
  import chroma_path_pkg::*;
(
  input wire logic   clk_sys,
  input wire logic   resetn,
  input wire logic   ce,
  luma_delay_if.store port
);
  logic [7:0] cells [LUMA_LAG];
  logic [7:0] rd_ff;

  always_ff @(posedge clk_sys) begin
    if (ce && port.wrEn) begin
      cells[port.addr] <= port.wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_ff <= 8'h00;
    end else if (ce && port.wrEn) begin
      rd_ff <= cells[port.addr];
    end
  end

  assign port.rdData = rd_ff;
endmodule // luma_delay_mem

// ==== rtl/chroma_transient_output_path.sv ====
// Chroma saturation/hue, 4:1:1 to 4:2:2 interpolation, transient sharpening,
// output formatting and active window strobe.
// Assumes inputs synchronous to clk_sys; chroma nibbles follow the 4:1:1 layout.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module chroma_transient_output_path
  import chroma_path_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] writeData,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  output logic      [31:0] readData,
  input  wire logic        sampleValid,
  input  wire logic        lineStart,
  input  wire logic        frameStart,
  input  wire logic [7:0]  lumaIn,
  input  wire logic [3:0]  chromaIn,
  output logic      [7:0]  lumaOut,
  output logic      [7:0]  chromaOut,
  output logic             outValid,
  output logic             active_window_strobe
);
  typedef logic signed [7:0] smp_type;

  // Register file
  logic [6:0]  ctrl_ff, nxt_ctrl;
  logic [15:0] sat_ff, nxt_sat;
  logic [20:0] sharp_ff, nxt_sharp;
  logic [31:0] win_ff, nxt_win;
  logic [31:0] rd_ff, nxt_rd;
  logic [9:0]  lineCnt_ff, nxt_lineCnt;
  logic        oddLine_ff, nxt_oddLine;
  logic        strobe_ff, nxt_strobe;

  logic       sharpen_enable, correction_filter_select, studioLevel;
  logic [1:0] leadSel;
  logic [4:0] gainU, gainV;
  logic [6:0] step_threshold;
  logic [3:0] coring;
  format_type fmt;
  assign sharpen_enable           = ctrl_ff[CTRL_EN_BIT];
  assign correction_filter_select = ctrl_ff[CTRL_FSEL_BIT];
  assign studioLevel              = ctrl_ff[CTRL_STD_BIT];
  assign leadSel                  = ctrl_ff[CTRL_LEAD_LSB +: 2];
  assign fmt      = (ctrl_ff[CTRL_FMT_LSB +: 2] == FMT_ORTH422) ? FMT_ORTH422 :
                    (ctrl_ff[CTRL_FMT_LSB +: 2] == FMT_ORTH411) ? FMT_ORTH411 : FMT_NONORTH;
  assign gainU          = sharp_ff[GAINU_LSB +: 5];
  assign gainV          = sharp_ff[GAINV_LSB +: 5];
  assign step_threshold = sharp_ff[THR_LSB +: 7];
  assign coring         = sharp_ff[COR_LSB +: 4];

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_sat   = sat_ff;
    nxt_sharp = sharp_ff;
    nxt_win   = win_ff;
    nxt_rd    = 32'h00000000;
    if (writeStrobe) begin
      unique case (regAddr)
        ADDR_CTRL:  nxt_ctrl  = writeData[6:0];
        ADDR_SAT:   nxt_sat   = writeData[15:0];
        ADDR_SHARP: nxt_sharp = writeData[20:0];
        ADDR_WIN:   nxt_win   = writeData;
        default:    nxt_ctrl  = ctrl_ff;
      endcase
    end
    if (readStrobe) begin
      unique case (regAddr)
        ADDR_CTRL:   nxt_rd = {25'h0000000, ctrl_ff};
        ADDR_SAT:    nxt_rd = {16'h0000, sat_ff};
        ADDR_SHARP:  nxt_rd = {11'h000, sharp_ff};
        ADDR_WIN:    nxt_rd = win_ff;
        ADDR_STATUS: nxt_rd = {20'h00000, lineCnt_ff, strobe_ff, oddLine_ff};
        default:     nxt_rd = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_ff  <= CTRL_RST;
      sat_ff   <= SAT_RST;
      sharp_ff <= SHARP_RST;
      win_ff   <= WIN_RST;
      rd_ff    <= 32'h00000000;
    end else if (ce) begin
      ctrl_ff  <= nxt_ctrl;
      sat_ff   <= nxt_sat;
      sharp_ff <= nxt_sharp;
      win_ff   <= nxt_win;
      rd_ff    <= nxt_rd;
    end
  end
  assign readData = rd_ff;

  // Clamp of a scaled product sum to the signed 8-bit range
  function automatic smp_type clamp8(input logic signed [17:0] x);
    logic signed [17:0] s;
    s = x >>> SAT_SHIFT;
    if (s > CLAMP_HI) begin
      clamp8 = 8'sh7F;
    end else if (s < CLAMP_LO) begin
      clamp8 = -8'sh80;
    end else begin
      clamp8 = s[7:0];
    end
  endfunction

  function automatic smp_type max3(input smp_type a, input smp_type b, input smp_type c);
    max3 = (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
  endfunction

  function automatic smp_type min3(input smp_type a, input smp_type b, input smp_type c);
    min3 = (a < b) ? ((a < c) ? a : c) : ((b < c) ? b : c);
  endfunction

  // Transient improvement of one centre sample from its four neighbours
  function automatic smp_type improve(input smp_type m2, input smp_type m1, input smp_type c,
                                      input smp_type p1, input smp_type p2, input logic [4:0] g);
    logic signed [9:0]  lap;
    logic signed [9:0]  step;
    logic signed [15:0] prod;
    logic signed [15:0] corr;
    logic signed [15:0] sum;
    smp_type            hi;
    smp_type            lo;
    lap  = correction_filter_select ? 10'(2 * c - m2 - p2) : 10'(2 * c - m1 - p1);
    step = 10'(p1 - m1);
    if (step < 0) begin
      step = -step;
    end
    prod = 16'(lap * $signed({1'b0, g}));
    corr = prod >>> GAIN_SHIFT;
    if (corr <= $signed({12'h000, coring}) && -corr <= $signed({12'h000, coring})) begin
      corr = 16'sh0000;
    end
    sum = 16'(c) + corr;
    hi  = max3(m1, c, p1);
    lo  = min3(m1, c, p1);
    if (!sharpen_enable) begin
      improve = c;
    end else if (step > $signed({2'b00, step_threshold, 1'b0})) begin
      improve = (sum > 16'(hi)) ? hi : (sum < 16'(lo)) ? lo : sum[7:0];
    end else begin
      // Median of three rejects single-sample spikes in flat areas
      improve = c + m1 + p1 - hi - lo;
    end
  endfunction

  // Input phase and chroma nibble assembly
  phase_type  phase_ff, nxt_phase;
  logic [5:0] uAcc_ff, nxt_uAcc, vAcc_ff, nxt_vAcc;
  smp_type    uHue_ff, nxt_uHue, vHue_ff, nxt_vHue;
  logic       blkDone_ff, nxt_blkDone;
  logic signed [17:0] rawV, rawU;
  smp_type    uIn, vIn, satCos, satSin;
  assign uIn    = {uAcc_ff, chromaIn[3:2]};
  assign vIn    = {vAcc_ff, chromaIn[1:0]};
  assign satCos = sat_ff[15:8];
  assign satSin = sat_ff[7:0];
  assign rawV   = 18'(vIn * satCos) - 18'(uIn * satSin);
  assign rawU   = 18'(vIn * satSin) + 18'(uIn * satCos);

  always_comb begin
    nxt_phase   = phase_ff;
    nxt_uAcc    = uAcc_ff;
    nxt_vAcc    = vAcc_ff;
    nxt_uHue    = uHue_ff;
    nxt_vHue    = vHue_ff;
    nxt_blkDone = 1'b0;
    if (lineStart) begin
      nxt_phase = PH0;
    end else if (sampleValid) begin
      nxt_uAcc = {uAcc_ff[3:0], chromaIn[3:2]};
      nxt_vAcc = {vAcc_ff[3:0], chromaIn[1:0]};
      unique case (phase_ff)
        PH0: nxt_phase = PH1;
        PH1: nxt_phase = PH2;
        PH2: nxt_phase = PH3;
        PH3: begin
          nxt_phase   = PH0;
          nxt_uHue    = clamp8(rawU);
          nxt_vHue    = clamp8(rawV);
          nxt_blkDone = 1'b1;
        end
        default: nxt_phase = PH0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      phase_ff   <= PH0;
      uAcc_ff    <= 6'h00;
      vAcc_ff    <= 6'h00;
      uHue_ff    <= 8'sh00;
      vHue_ff    <= 8'sh00;
      blkDone_ff <= 1'b0;
    end else if (ce) begin
      phase_ff   <= nxt_phase;
      uAcc_ff    <= nxt_uAcc;
      vAcc_ff    <= nxt_vAcc;
      uHue_ff    <= nxt_uHue;
      vHue_ff    <= nxt_vHue;
      blkDone_ff <= nxt_blkDone;
    end
  end

  // 4:2:2 history, newest at index 0; two samples enter per block
  smp_type uHist_ff [6];
  smp_type vHist_ff [6];
  smp_type nxt_uHist [6];
  smp_type nxt_vHist [6];
  smp_type uBlk_ff [4];
  smp_type nxt_uBlk [4];
  smp_type vBlk_ff [4];
  smp_type nxt_vBlk [4];
  logic    blkReady_ff, nxt_blkReady;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      nxt_uHist[i] = uHist_ff[i];
      nxt_vHist[i] = vHist_ff[i];
    end
    for (int i = 0; i < 4; i++) begin
      nxt_uBlk[i] = uBlk_ff[i];
      nxt_vBlk[i] = vBlk_ff[i];
    end
    nxt_blkReady = 1'b0;
    if (blkDone_ff) begin
      for (int i = 2; i < 6; i++) begin
        nxt_uHist[i] = uHist_ff[i - 2];
        nxt_vHist[i] = vHist_ff[i - 2];
      end
      nxt_uHist[1] = 8'((9'(uHist_ff[0]) + 9'(uHue_ff)) >>> 1);
      nxt_vHist[1] = 8'((9'(vHist_ff[0]) + 9'(vHue_ff)) >>> 1);
      nxt_uHist[0] = uHue_ff;
      nxt_vHist[0] = vHue_ff;
      // Slots 0/1 hold one 4:2:2 pair; slot 2 keeps the raw hue for 4:1:1, slot 3 that of the block before
      nxt_uBlk[0]  = improve(uHist_ff[5], uHist_ff[4], uHist_ff[3], uHist_ff[2], uHist_ff[1], gainU);
      nxt_uBlk[1]  = improve(uHist_ff[4], uHist_ff[3], uHist_ff[2], uHist_ff[1], uHist_ff[0], gainU);
      nxt_vBlk[0]  = improve(vHist_ff[5], vHist_ff[4], vHist_ff[3], vHist_ff[2], vHist_ff[1], gainV);
      nxt_vBlk[1]  = improve(vHist_ff[4], vHist_ff[3], vHist_ff[2], vHist_ff[1], vHist_ff[0], gainV);
      nxt_uBlk[2]  = uHue_ff;
      nxt_vBlk[2]  = vHue_ff;
      nxt_uBlk[3]  = uBlk_ff[2];
      nxt_vBlk[3]  = vBlk_ff[2];
      nxt_blkReady = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < 6; i++) begin
        uHist_ff[i] <= 8'sh00;
        vHist_ff[i] <= 8'sh00;
      end
      for (int i = 0; i < 4; i++) begin
        uBlk_ff[i] <= 8'sh00;
        vBlk_ff[i] <= 8'sh00;
      end
      blkReady_ff <= 1'b0;
    end else if (ce) begin
      uHist_ff    <= nxt_uHist;
      vHist_ff    <= nxt_vHist;
      uBlk_ff     <= nxt_uBlk;
      vBlk_ff     <= nxt_vBlk;
      blkReady_ff <= nxt_blkReady;
    end
  end

  // Luma delay line sized to the chroma latency of two blocks
  luma_delay_if        lumaPort ();
  logic [LAG_AW-1:0]   lagPtr_ff, nxt_lagPtr;
  // Refused samples must not advance the delay, or luma slips against chroma
  assign lumaPort.wrEn   = sampleValid && !lineStart && !frameStart;
  assign lumaPort.addr   = lagPtr_ff;
  assign lumaPort.wrData = lumaIn;
  assign nxt_lagPtr      = lumaPort.wrEn ? LAG_AW'(lagPtr_ff + 1'b1) : lagPtr_ff;

  luma_delay_mem lumaMem (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .port    (lumaPort)
  );

  // Window counters and output stage
  logic [10:0] pixCnt_ff, nxt_pixCnt;
  phase_type   outPhase_ff, nxt_outPhase;
  logic        stage_ff, nxt_stage;
  logic [7:0]  lumaOut_ff, nxt_lumaOut, chromaOut_ff, nxt_chromaOut;
  logic        outValid_ff, nxt_outValid;
  logic [11:0] hPos, hBeg, hEnd;
  logic [10:0] vBeg, vEnd;
  logic signed [17:0] lumaScaled;
  smp_type     selU, selV, selC;
  logic [2:0]  bitSel;

  assign hPos = 12'(pixCnt_ff) + 12'(leadSel);
  assign hBeg = 12'(win_ff[15:8] << H_STEP_SHIFT) + 12'(LUMA_LAG);
  assign hEnd = hBeg + 12'(win_ff[7:0] << H_STEP_SHIFT);
  assign vBeg = 11'(win_ff[31:24] << V_STEP_SHIFT);
  assign vEnd = vBeg + 11'(win_ff[23:16] << V_STEP_SHIFT);
  assign lumaScaled = 18'((10'($signed({2'b00, lumaPort.rdData})) - BLACK_NATIVE) * STUDIO_MUL);

  always_comb begin
    nxt_pixCnt    = pixCnt_ff;
    nxt_lineCnt   = lineCnt_ff;
    nxt_oddLine   = oddLine_ff;
    nxt_strobe    = strobe_ff;
    nxt_outPhase  = outPhase_ff;
    nxt_stage     = 1'b0;
    nxt_lumaOut   = lumaOut_ff;
    nxt_chromaOut = chromaOut_ff;
    nxt_outValid  = 1'b0;
    selU   = 8'sh00;
    selV   = 8'sh00;
    selC   = 8'sh00;
    bitSel = 3'h0;
    if (frameStart) begin
      nxt_lineCnt = 10'h000;
      nxt_oddLine = 1'b0;
      nxt_pixCnt  = 11'h000;
    end else if (lineStart) begin
      nxt_lineCnt = 10'(lineCnt_ff + 1'b1);
      nxt_oddLine = !oddLine_ff;
      nxt_pixCnt  = 11'h000;
    end else if (sampleValid) begin
      nxt_pixCnt   = 11'(pixCnt_ff + 1'b1);
      nxt_outPhase = phase_ff;
      nxt_stage    = 1'b1;
      nxt_strobe   = (hPos >= hBeg) && (hPos < hEnd) &&
                     ({1'b0, lineCnt_ff} >= vBeg) && ({1'b0, lineCnt_ff} < vEnd);
    end
    if (stage_ff) begin
      nxt_outValid = 1'b1;
      selU = (outPhase_ff == PH0 || outPhase_ff == PH1) ? uBlk_ff[0] : uBlk_ff[1];
      selV = (outPhase_ff == PH0 || outPhase_ff == PH1) ? vBlk_ff[0] : vBlk_ff[1];
      unique case (outPhase_ff)
        PH0: bitSel = 3'h6;
        PH1: bitSel = 3'h4;
        PH2: bitSel = 3'h2;
        PH3: bitSel = 3'h0;
        default: bitSel = 3'h0;
      endcase
      if (fmt == FMT_ORTH422) begin
        selC = (outPhase_ff == PH0 || outPhase_ff == PH2) ? selU : selV;
      end else begin
        // Line parity decides whether V or U leads the pair
        selC = ((outPhase_ff == PH0 || outPhase_ff == PH2) ^ oddLine_ff) ? selV : selU;
      end
      if (fmt == FMT_ORTH411) begin
        nxt_chromaOut = {4'h0, uBlk_ff[3][bitSel +: 2], vBlk_ff[3][bitSel +: 2]};
        if (studioLevel) begin
          nxt_chromaOut = {4'h0, uBlk_ff[3][bitSel +: 2] ^ {bitSel == 3'h6, 1'b0},
                           vBlk_ff[3][bitSel +: 2] ^ {bitSel == 3'h6, 1'b0}};
        end
      end else begin
        nxt_chromaOut = studioLevel ? {!selC[7], selC[6:0]} : selC;
      end
      if (studioLevel) begin
        if ((lumaScaled >>> STUDIO_SHIFT) + BLACK_STUDIO > WHITE_STUDIO + 18'sh0000F) begin
          nxt_lumaOut = 8'hFF;
        end else if ((lumaScaled >>> STUDIO_SHIFT) + BLACK_STUDIO < 18'sh00000) begin
          nxt_lumaOut = 8'h00;
        end else begin
          nxt_lumaOut = 8'((lumaScaled >>> STUDIO_SHIFT) + BLACK_STUDIO);
        end
      end else begin
        nxt_lumaOut = lumaPort.rdData;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pixCnt_ff    <= 11'h000;
      lineCnt_ff   <= 10'h000;
      oddLine_ff   <= 1'b0;
      strobe_ff    <= 1'b0;
      outPhase_ff  <= PH0;
      stage_ff     <= 1'b0;
      lumaOut_ff   <= 8'h00;
      chromaOut_ff <= 8'h00;
      outValid_ff  <= 1'b0;
      lagPtr_ff    <= '0;
    end else if (ce) begin
      pixCnt_ff    <= nxt_pixCnt;
      lineCnt_ff   <= nxt_lineCnt;
      oddLine_ff   <= nxt_oddLine;
      strobe_ff    <= nxt_strobe;
      outPhase_ff  <= nxt_outPhase;
      stage_ff     <= nxt_stage;
      lumaOut_ff   <= nxt_lumaOut;
      chromaOut_ff <= nxt_chromaOut;
      outValid_ff  <= nxt_outValid;
      lagPtr_ff    <= nxt_lagPtr;
    end
  end
  assign lumaOut              = lumaOut_ff;
  assign chromaOut            = chromaOut_ff;
  assign outValid             = outValid_ff;
  assign active_window_strobe = strobe_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_hue_clamp_hi: assert property (ce && sampleValid && !lineStart && phase_ff == PH3 &&
    (rawU >>> SAT_SHIFT) > CLAMP_HI |=> uHue_ff == 8'sh7F) else $error("U not clamped high");
  a_hue_clamp_lo: assert property (ce && sampleValid && !lineStart && phase_ff == PH3 &&
    (rawV >>> SAT_SHIFT) < CLAMP_LO |=> vHue_ff == -8'sh80) else $error("V not clamped low");
  a_interp_mid: assert property (ce && blkDone_ff |=>
    uHist_ff[1] == 8'((9'($past(uHist_ff[0])) + 9'($past(uHue_ff))) >>> 1))
    else $error("midpoint sample wrong");
  a_bypass_off: assert property (ce && blkDone_ff && !sharpen_enable |=>
    uBlk_ff[1] == $past(uHist_ff[2]) && vBlk_ff[0] == $past(vHist_ff[3]))
    else $error("disabled path altered chroma");
  a_limit_range: assert property (ce && blkDone_ff |=>
    uBlk_ff[1] <= max3($past(uHist_ff[3]), $past(uHist_ff[2]), $past(uHist_ff[1])) &&
    uBlk_ff[1] >= min3($past(uHist_ff[3]), $past(uHist_ff[2]), $past(uHist_ff[1])))
    else $error("sharpened sample overshoots");
  a_nibble_high: assert property (ce && stage_ff && fmt == FMT_ORTH411 |=>
    chromaOut[7:4] == 4'h0) else $error("4:1:1 upper lines not zero");
  a_window_empty: assert property (ce && win_ff[7:0] == 8'h00 ##1 ce && win_ff[7:0] == 8'h00
    |-> !active_window_strobe) else $error("strobe with zero length");
  a_unmapped_zero: assert property (ce && readStrobe && regAddr > ADDR_STATUS |=>
    readData == 32'h00000000) else $error("unmapped read not zero");
  a_wr_rd_back: assert property (ce && writeStrobe && regAddr == ADDR_WIN ##1
    ce && readStrobe && regAddr == ADDR_WIN |=> readData == $past(writeData, 2))
    else $error("window register readback wrong");
  a_out_after_valid: assert property (ce && sampleValid && !lineStart && !frameStart ##1 ce
    |=> outValid) else $error("output sample missing");
  c_block_done:  cover property (ce && blkReady_ff);
  c_strobe_rise: cover property (ce && !active_window_strobe ##1 active_window_strobe);
  c_studio_out:  cover property (ce && outValid && studioLevel && fmt == FMT_ORTH422);
endmodule // chroma_transient_output_path

// ==== testbench/video_source.sv ====
// Upstream decoder model: frame, line and sample pulses with random luma.
// Assumes the path takes one pulse per cycle and never stalls the source.
`timescale 1ns/1ps
module video_source (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       run,
  output logic            sampleValid,
  output logic            lineStart,
  output logic            frameStart,
  output logic [7:0]      lumaIn,
  output logic [3:0]      chromaIn
);
  int   seed = 78;
  int   pix  = 0;
  logic first = 1'b1;
  initial begin
    {sampleValid, lineStart, frameStart, lumaIn, chromaIn} = '0;
  end
  always @(posedge clk_sys) begin
    {sampleValid, lineStart, frameStart} <= 3'h0;
    // Idle bus shows no stale sample
    lumaIn   <= ~lumaIn;
    chromaIn <= ~chromaIn;
    if (resetn && run) begin
      if (pix == 0) begin
        lineStart  <= 1'b1;
        frameStart <= first;
        first      <= 1'b0;
      end else if ($random(seed) & 1) begin
        sampleValid <= 1'b1;
        lumaIn      <= 8'h20 + 8'($unsigned($random(seed)) % 96);
        chromaIn    <= 4'($random(seed));
      end
      pix <= (pix + 1) % 64;
    end
  end
endmodule // video_source

// ==== testbench/testbench.sv ====
// Bench for the chroma output path: register port and luma alignment.
// Assumes one clock; the source model feeds the video inputs.
`timescale 1ns/1ps
module testbench;
  import chroma_path_pkg::*;
  logic clk_sys = 0, resetn = 0, run = 0, studio = 0;
  logic writeStrobe = 0, readStrobe = 0, sampleValid, lineStart, frameStart, outValid, strobe;
  logic [3:0] regAddr = 4'h0, chromaIn;
  logic [31:0] writeData = 32'h0, readData;
  logic [7:0] lumaIn, lumaOut, chromaOut;
  logic [7:0] hist[$];
  int num_errors = 0, total_checks = 0, outs = 0, skip = 0;
  localparam logic [31:0] WIN_SET = 32'h01040101;
  logic m411 = 0, wDue = 0, wExp = 0;
  logic [7:0] uN = 8'h00, vN = 8'h00, cExp;
  logic [15:0] e;
  logic [31:0] win = 32'h0;
  // Two zero entries stand for the cleared block slots after reset
  logic [15:0] hq[$] = '{16'h0000, 16'h0000};
  logic [7:0] cq[$];
  int ph = 0, pc = 0, lc = 0, u, v;
  int cs = int'($signed(SAT_RST[15:8])), sn = int'($signed(SAT_RST[7:0]));
  video_source src (.clk_sys(clk_sys), .resetn(resetn), .run(run), .sampleValid(sampleValid),
    .lineStart(lineStart), .frameStart(frameStart), .lumaIn(lumaIn), .chromaIn(chromaIn));
  chroma_transient_output_path dut (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
    .regAddr(regAddr), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .sampleValid(sampleValid),
    .lineStart(lineStart), .frameStart(frameStart), .lumaIn(lumaIn), .chromaIn(chromaIn),
    .lumaOut(lumaOut), .chromaOut(chromaOut), .outValid(outValid),
    .active_window_strobe(strobe));
  initial forever #20 clk_sys = ~clk_sys;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Called just after a rising edge; strobe stands until the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    {regAddr, writeData, writeStrobe, readStrobe} <= {a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    {regAddr, readStrobe, writeStrobe} <= {a, 1'b1, 1'b0};
    @(posedge clk_sys) readStrobe <= 1'b0;
    @(posedge clk_sys) check(readData, exp);
  endtask
  // Rotated chroma component, limited to the signed byte range
  function automatic logic [7:0] sat8(input int x);
    int s;
    s = x >>> SAT_SHIFT;
    return (s > 127) ? 8'h7F : (s < -128) ? 8'h80 : 8'(s);
  endfunction
  // Studio luma scaling, clamped to the byte range
  function automatic logic [7:0] lumaExp(input logic [7:0] y, input logic s);
    int v;
    v = 16 + (((int'(y) - 32) * 151) >>> 6);
    if (v < 0) v = 0;
    if (v > 255) v = 255;
    return s ? 8'(v) : y;
  endfunction
  always @(posedge clk_sys) begin
    if (wDue) check(strobe, wExp);
    wDue = 1'b0;
    if (frameStart) begin
      lc = 0;
      pc = 0;
      ph = 0;
    end else if (lineStart) begin
      lc++;
      pc = 0;
      ph = 0;
    end else if (sampleValid) begin
      hist.push_back(lumaIn);
      wExp = pc >= LUMA_LAG + 8 * win[15:8] && pc < LUMA_LAG + 8 * (win[15:8] + win[7:0]) &&
             lc >= 2 * win[31:24] && lc < 2 * (win[31:24] + win[23:16]);
      wDue = 1'b1;
      pc++;
      uN = {uN[5:0], chromaIn[3:2]};
      vN = {vN[5:0], chromaIn[1:0]};
      // Block output slots carry the hue of the block two earlier
      e = hq[hq.size()-2];
      cq.push_back({4'h0, e[15-2*ph -: 2], e[7-2*ph -: 2]});
      if (ph == 3) begin
        u = $signed(uN);
        v = $signed(vN);
        hq.push_back({sat8(v * sn + u * cs), sat8(v * cs - u * sn)});
      end
      ph = (ph + 1) % 4;
    end
    if (outValid) begin
      cExp = cq.pop_front();
      if (m411) check(chromaOut, cExp);
      // Luma results just after the switch to studio level are not compared
      if (outs >= 8 && skip == 0) check(lumaOut, lumaExp(hist[outs-8], studio));
      if (skip > 0) skip--;
      outs++;
    end
  end
  task automatic stream(input int n);
    int i;
    {run, writeStrobe, readStrobe} <= 3'b100;
    for (i = 0; i < 4000 && outs < n; i++) @(posedge clk_sys);
    if (outs < n) begin
      num_errors++;
      report_and_stop();
    end
    run <= 1'b0;
    repeat (12) @(posedge clk_sys);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(ADDR_SAT, 32'(SAT_RST));
    rd(ADDR_CTRL, 32'h0);
    rd(4'h5, 32'h0);
    wr(4'h7, 32'hFFFFFFFF);
    wr(ADDR_WIN, WIN_SET);
    rd(ADDR_WIN, WIN_SET);
    win = WIN_SET;
    wr(ADDR_CTRL, 32'h00000001);
    rd(ADDR_CTRL, 32'h00000001);
    stream(200);
    wr(ADDR_CTRL, 32'h00000011);
    studio = 1'b1;
    skip = 12;
    stream(400);
    wr(ADDR_CTRL, 32'h00000008);
    studio = 1'b0;
    m411 = 1'b1;
    stream(600);
    report_and_stop();
  end
endmodule // testbench
